// file: logic/pir_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PIR_MAP_SVH
`define PIR_MAP_SVH
`define PIR_CFG_OFF   8'h00
`define PIR_EN1_OFF   8'h04
`define PIR_EN2_OFF   8'h08
`define PIR_FLP_OFF   8'h0c
`define PIR_PCTL_OFF  8'h10
`define PIR_STAT_OFF  8'h14
`define PIR_MASK_OFF  8'h18
`define PIR_JMP_OFF   8'h1c
`define PIR_LVL_OFF   8'h20
`define PIR_CFG_ADPT  0
`define PIR_CFG_P1    1
`define PIR_CFG_P2    3
`define PIR_CFG_ENH   5
`define PIR_CFG_RST   8'h08
`define PIR_FLP_IRQEN 3
`define PIR_PAR_IRQEN 4
`define PIR_EV_W      5
`define PIR_PULSE_NS  100
`define PIR_CLK_MHZ   50
`define PIR_PULSE_CYC ((`PIR_PULSE_NS * `PIR_CLK_MHZ + 999) / 1000)
`define PIR_OKAY      2'h0
`define PIR_SLVERR    2'h2
`endif

// file: logic/pir_pkg.sv
// Types of the peripheral interrupt routing block
`default_nettype none

package pir_pkg;
   // Parallel output shaping states
   typedef enum logic [2:0] {
      PIR_P_IDLE  = 3'h1,
      PIR_P_PULSE = 3'h2,
      PIR_P_HOLD  = 3'h4
   } pir_pstate_t;

   // Whole state of the block
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        aw_held;
      logic        w_held;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic        wstb;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [7:0]  cfg;
      logic [3:0]  en1;
      logic [3:0]  en2;
      logic [7:0]  flp_ctl;
      logic [7:0]  pctl;
      logic [4:0]  stat;
      logic [4:0]  mask;
      logic [7:0]  jumper;
      logic        rst_prev;
      pir_pstate_t pst;
      logic [7:0]  pcnt;
      logic        host_a;
      logic        host_b;
      logic        ser1;
      logic        ser2;
      logic        flp;
      logic        par_o;
      logic        par_oe_n;
      logic        irq;
   } pir_state_t;
endpackage

`default_nettype wire

// file: logic/pir_top.sv
// Peripheral interrupt routing with AXI4-Lite register slave
//
// Summary of operation
// - Board build: COM1/COM3 ports drive line A
// - Board build: COM2/COM4 ports drive line B
// - Serial enables gate each port's request
// - Serial line drops once cause is serviced
// - Cleared enables or hardware reset disable serial
// - Adapter build: own output for first port
// - Adapter build: own output for second port
// - Floppy request gated by control bit 3
// - Parallel request gated by control bit 4
// - Enhanced parallel: open-drain low pulse, release
// - High reset input clears functional registers
// - Reset input leaves configuration untouched
// - Adapter: jumpers latched on reset falling edge
`timescale 1ns/1ps
`include "pir_map.svh"
`default_nettype none

module pir_top #(
   parameter int JUMPER_W = 4
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [7:0]          awaddr,
   input  wire logic                wvalid,
   output logic                     wready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   output logic                     bvalid,
   input  wire logic                bready,
   output logic [1:0]               bresp,
   input  wire logic                arvalid,
   output logic                     arready,
   input  wire logic [7:0]          araddr,
   output logic                     rvalid,
   input  wire logic                rready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   input  wire logic                hw_reset,
   input  wire logic [JUMPER_W-1:0] jumper_sel,
   input  wire logic [3:0]          first_serial_cause,
   input  wire logic [3:0]          second_serial_cause,
   input  wire logic                floppy_cause,
   input  wire logic                parallel_cause,
   output logic                     host_serial_irq_a,
   output logic                     host_serial_irq_b,
   output logic                     first_serial_irq_out,
   output logic                     second_serial_irq_out,
   output logic                     floppy_irq_out,
   output logic                     parallel_irq_out,
   output logic                     parallel_irq_oe_n,
   output logic                     irq
);

   ////////////////////////////////////////////////////////////////////
   // Parameter check and constants

   // Jumper field is one byte wide in the state record
   if (JUMPER_W < 1 || JUMPER_W > 8) begin : g_chk
      $error("JUMPER_W must lie in 1..8");
   end

   localparam logic [7:0] PCYC = 8'(`PIR_PULSE_CYC);
   localparam logic [3:0] NONE = 4'hf;

   // Register index of an address, NONE when unmapped
   function automatic logic [3:0] reg_sel(input logic [7:0] a);
      if (a == `PIR_CFG_OFF) reg_sel = 4'h0;
      else if (a == `PIR_EN1_OFF) reg_sel = 4'h1;
      else if (a == `PIR_EN2_OFF) reg_sel = 4'h2;
      else if (a == `PIR_FLP_OFF) reg_sel = 4'h3;
      else if (a == `PIR_PCTL_OFF) reg_sel = 4'h4;
      else if (a == `PIR_STAT_OFF) reg_sel = 4'h5;
      else if (a == `PIR_MASK_OFF) reg_sel = 4'h6;
      else if (a == `PIR_JMP_OFF) reg_sel = 4'h7;
      else if (a == `PIR_LVL_OFF) reg_sel = 4'h8;
      else reg_sel = NONE;
   endfunction

   // Even address codes (COM1, COM3) map to line A
   function automatic logic on_line_a(input logic [1:0] code);
      on_line_a = ~code[0];
   endfunction

   ////////////////////////////////////////////////////////////////////
   // State and combinational helpers

   pir_pkg::pir_state_t s;                 // Registered state
   pir_pkg::pir_state_t next_s;            // Next state
   logic [3:0]          wsel;              // Held write target
   logic [3:0]          rsel;              // Read target
   logic                do_wr;             // Write executes
   logic                wr_en;             // Low byte is written
   logic                adapter;           // Adapter build
   logic                g1;                // Gated first port request
   logic                g2;                // Gated second port request
   logic                pg;                // Gated parallel request
   logic [1:0]          p1;                // First port address code
   logic [1:0]          p2;                // Second port address code
   logic [4:0]          clr;               // Status bits to clear
   logic [4:0]          ev;                // Events this cycle
   logic [31:0]         rd_val;            // Read mux result

   assign wsel    = reg_sel(s.awaddr);
   assign rsel    = reg_sel(araddr);
   assign do_wr   = s.aw_held && s.w_held && !s.bvalid;
   assign wr_en   = do_wr && s.wstb;
   assign adapter = s.cfg[`PIR_CFG_ADPT];
   assign p1      = s.cfg[`PIR_CFG_P1 +: 2];
   assign p2      = s.cfg[`PIR_CFG_P2 +: 2];
   // Reset input blocks requests at once, before enables clear
   assign g1 = |(first_serial_cause & s.en1) && !hw_reset;
   assign g2 = |(second_serial_cause & s.en2) && !hw_reset;
   assign pg = parallel_cause && s.pctl[`PIR_PAR_IRQEN] && !hw_reset;

   ////////////////////////////////////////////////////////////////////
   // Read data mux
   always_comb begin
      rd_val = 32'h0;
      if (rsel == 4'h0) rd_val[7:0] = s.cfg;
      else if (rsel == 4'h1) rd_val[3:0] = s.en1;
      else if (rsel == 4'h2) rd_val[3:0] = s.en2;
      else if (rsel == 4'h3) rd_val[7:0] = s.flp_ctl;
      else if (rsel == 4'h4) rd_val[7:0] = s.pctl;
      else if (rsel == 4'h5) rd_val[4:0] = s.stat;
      else if (rsel == 4'h6) rd_val[4:0] = s.mask;
      else if (rsel == 4'h7) rd_val[7:0] = s.jumper;
      else if (rsel == 4'h8) begin
         // Live pin levels, handy when debugging routing
         rd_val[7:0] = {s.par_oe_n, s.par_o, s.flp, s.ser2,
                        s.ser1, s.host_b, s.host_a, s.irq};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_s = s;
      clr    = 5'h0;
      ev     = 5'h0;

      // Address and data are taken in either order
      if (awvalid && s.awready) begin
         next_s.awaddr  = awaddr;
         next_s.aw_held = 1'b1;
         next_s.awready = 1'b0;
      end
      if (wvalid && s.wready) begin
         next_s.wdata  = wdata;
         next_s.wstb   = wstrb[0];
         next_s.w_held = 1'b1;
         next_s.wready = 1'b0;
      end
      // Both held: perform the write and answer
      if (do_wr) begin
         next_s.bvalid  = 1'b1;
         next_s.aw_held = 1'b0;
         next_s.w_held  = 1'b0;
         next_s.bresp   = (wsel == NONE) ? `PIR_SLVERR : `PIR_OKAY;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid  = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready  = 1'b1;
      end

      // Register writes; only byte lane 0 carries fields
      if (wr_en) begin
         if (wsel == 4'h0) next_s.cfg = s.wdata[7:0];
         else if (wsel == 4'h1) next_s.en1 = s.wdata[3:0];
         else if (wsel == 4'h2) next_s.en2 = s.wdata[3:0];
         else if (wsel == 4'h3) next_s.flp_ctl = s.wdata[7:0];
         else if (wsel == 4'h4) next_s.pctl = s.wdata[7:0];
         else if (wsel == 4'h5) clr = s.wdata[4:0];
         else if (wsel == 4'h6) next_s.mask = s.wdata[4:0];
      end

      // Functional registers clear under reset input; cfg is kept
      if (hw_reset) begin
         next_s.en1     = 4'h0;
         next_s.en2     = 4'h0;
         next_s.flp_ctl = 8'h0;
         next_s.pctl    = 8'h0;
      end

      // Adapter build: jumpers captured on the falling edge of the reset input
      next_s.rst_prev = hw_reset;
      if (s.rst_prev && !hw_reset && adapter) begin
         next_s.jumper = 8'(jumper_sel);
      end

      // Serial routing; levels follow the gated causes
      next_s.host_a = !adapter && ((g1 && on_line_a(p1))
                                || (g2 && on_line_a(p2)));
      next_s.host_b = !adapter && ((g1 && !on_line_a(p1))
                                || (g2 && !on_line_a(p2)));
      next_s.ser1 = adapter && g1;
      next_s.ser2 = adapter && g2;
      next_s.flp  = floppy_cause && s.flp_ctl[`PIR_FLP_IRQEN]
                    && !hw_reset;

      // Parallel output: level when plain, shared pulse when enhanced
      if (!s.cfg[`PIR_CFG_ENH]) begin
         next_s.pst      = pir_pkg::PIR_P_IDLE;
         next_s.par_oe_n = 1'b0;
         next_s.par_o    = pg;
      end else begin
         case (s.pst)
            pir_pkg::PIR_P_IDLE: begin
               next_s.par_o    = 1'b0;
               next_s.par_oe_n = 1'b1;
               if (pg) begin
                  next_s.pst      = pir_pkg::PIR_P_PULSE;
                  next_s.par_oe_n = 1'b0;
                  next_s.pcnt     = PCYC - 8'h1;
               end
            end
            pir_pkg::PIR_P_PULSE: begin
               if (s.pcnt == 8'h0) begin
                  next_s.pst      = pir_pkg::PIR_P_HOLD;
                  next_s.par_oe_n = 1'b1;
               end else begin
                  next_s.pcnt = s.pcnt - 8'h1;
               end
            end
            pir_pkg::PIR_P_HOLD: begin
               // One pulse per request; re-arm once it drops
               if (!pg) next_s.pst = pir_pkg::PIR_P_IDLE;
            end
            default: begin
               next_s.pst      = pir_pkg::PIR_P_IDLE;
               next_s.par_oe_n = 1'b1;
            end
         endcase
      end

      // Events: rising request levels and reset release
      ev[0] = (next_s.host_a | next_s.ser1) & ~(s.host_a | s.ser1);
      ev[1] = (next_s.host_b | next_s.ser2) & ~(s.host_b | s.ser2);
      ev[2] = next_s.flp & ~s.flp;
      ev[3] = (next_s.pst == pir_pkg::PIR_P_PULSE
               && s.pst != pir_pkg::PIR_P_PULSE)
              || (next_s.par_o && !s.par_o);
      ev[4] = s.rst_prev && !hw_reset;
      // Set wins over a clear in the same cycle
      next_s.stat = (s.stat & ~clr) | ev;
      next_s.irq  = |(next_s.stat & next_s.mask);

      // Read channel: one outstanding read
      if (arvalid && s.arready) begin
         next_s.arready = 1'b0;
         next_s.rvalid  = 1'b1;
         next_s.rdata   = rd_val;
         next_s.rresp   = (rsel == NONE) ? `PIR_SLVERR : `PIR_OKAY;
      end
      if (s.rvalid && rready) begin
         next_s.rvalid  = 1'b0;
         next_s.arready = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register; configuration resets only here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s          <= '0;
         s.awready  <= 1'b1;
         s.wready   <= 1'b1;
         s.arready  <= 1'b1;
         s.cfg      <= `PIR_CFG_RST;
         s.pst      <= pir_pkg::PIR_P_IDLE;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign awready               = s.awready;
   assign wready                = s.wready;
   assign bvalid                = s.bvalid;
   assign bresp                 = s.bresp;
   assign arready               = s.arready;
   assign rvalid                = s.rvalid;
   assign rdata                 = s.rdata;
   assign rresp                 = s.rresp;
   assign host_serial_irq_a     = s.host_a;
   assign host_serial_irq_b     = s.host_b;
   assign first_serial_irq_out  = s.ser1;
   assign second_serial_irq_out = s.ser2;
   assign floppy_irq_out        = s.flp;
   assign parallel_irq_out      = s.par_o;
   assign parallel_irq_oe_n     = s.par_oe_n;
   assign irq                   = s.irq;

   ////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   line_a_route_a: assert property (!adapter && g1 && on_line_a(p1)
      |=> host_serial_irq_a && !first_serial_irq_out)
      else $error("line A not driven from its port");
   line_b_route_a: assert property (!adapter && g2 && !on_line_a(p2)
      |=> host_serial_irq_b && !second_serial_irq_out)
      else $error("line B not driven from its port");
   ser_gate_a: assert property (s.en1 == 4'h0 && s.en2 == 4'h0
      |=> !host_serial_irq_a && !host_serial_irq_b
          && !first_serial_irq_out && !second_serial_irq_out)
      else $error("disabled serial port raised a line");
   ser_service_a: assert property (!g1 && !g2
      |=> !host_serial_irq_a && !host_serial_irq_b)
      else $error("serial line stayed high after service");
   hw_reset_off_a: assert property (hw_reset |=> s.en1 == 4'h0
      && s.en2 == 4'h0 && s.pctl == 8'h0 && s.flp_ctl == 8'h0
      && !first_serial_irq_out && !host_serial_irq_a)
      else $error("reset input did not clear functions");
   adapter_first_a: assert property (adapter && g1
      |=> first_serial_irq_out && !host_serial_irq_a
          && !host_serial_irq_b)
      else $error("first adapter output wrong");
   adapter_second_a: assert property (adapter
      |=> second_serial_irq_out == $past(g2) && !host_serial_irq_b)
      else $error("second adapter output wrong");
   flp_gate_a: assert property (floppy_cause != floppy_irq_out
      && !hw_reset && s.flp_ctl[`PIR_FLP_IRQEN]
      |=> floppy_irq_out == $past(floppy_cause))
      else $error("floppy output ignores its enable");
   par_level_a: assert property (!s.cfg[`PIR_CFG_ENH]
      |=> !parallel_irq_oe_n && parallel_irq_out == $past(pg))
      else $error("plain parallel level wrong");
   // Leaving enhanced mode mid-pulse hands the pin back to plain drive
   par_pulse_a: assert property (disable iff (!aresetn || hw_reset
         || !s.cfg[`PIR_CFG_ENH])
      s.pst == pir_pkg::PIR_P_IDLE && s.cfg[`PIR_CFG_ENH] && pg
      |=> (!parallel_irq_oe_n && !parallel_irq_out)[*5]
          ##1 parallel_irq_oe_n)
      else $error("parallel pulse width wrong");
   cfg_keep_a: assert property (hw_reset && !(wr_en && wsel == 4'h0)
      |=> $stable(s.cfg))
      else $error("configuration changed by reset input");
   jumper_latch_a: assert property (s.rst_prev && !hw_reset && adapter
      |=> s.jumper == 8'($past(jumper_sel)))
      else $error("jumpers not latched at reset release");

   cov_line_a_c: cover property ($rose(host_serial_irq_a));
   cov_pulse_c:  cover property ($fell(parallel_irq_oe_n)
                                 && s.cfg[`PIR_CFG_ENH]);
   cov_jumper_c: cover property (s.rst_prev && !hw_reset && adapter);
   cov_irq_c:    cover property ($rose(irq));

endmodule

`default_nettype wire

// file: sim/pir_host_model.sv
// Host-side model of the shared parallel request line and its pull-up
`timescale 1ns/1ps
`default_nettype none

module pir_host_model (
   input  wire logic       aclk,
   input  wire logic       clr,
   input  wire logic       par_o,
   input  wire logic       par_oe_n,
   output wire logic       par_line,
   output logic [7:0]      low_len,
   output logic [7:0]      pulses
);
   logic [7:0] run;   // Cycles the line has been low so far

   // A released line floats up through the board pull-up, so sharing
   // sources only ever pull it low
   assign par_line = par_oe_n ? 1'b1 : par_o;

   ////////////////////////////////////////////////////////////////
   // Measure the width of each low pulse and count the pulses
   always_ff @(posedge aclk) begin
      if (clr) begin
         run     <= 8'h00;
         low_len <= 8'h00;
         pulses  <= 8'h00;
      end else if (!par_line) begin
         run <= run + 8'h01;
      end else begin
         // Line back high: record the finished pulse
         if (run != 8'h00) begin
            low_len <= run;
            pulses  <= pulses + 8'h01;
         end
         run <= 8'h00;
      end
   end
endmodule

`default_nettype wire

// file: sim/peripheral_interrupt_routing_bench.sv
// Self-checking bench for the peripheral interrupt routing block
`timescale 1ns/1ps
`include "pir_map.svh"
`default_nettype none

module peripheral_interrupt_routing_bench;
   logic        aclk, aresetn, hw_reset, clr;        // Clock and resets
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr, araddr;                      // Register offsets
   logic [31:0] wdata, rdata;                        // Data words
   logic [3:0]  wstrb, jumper_sel;
   logic [1:0]  bresp, rresp;
   logic [3:0]  first_serial_cause, second_serial_cause;
   logic        floppy_cause, parallel_cause;        // Raw requests
   logic        host_serial_irq_a, host_serial_irq_b, irq;
   logic        first_serial_irq_out, second_serial_irq_out;
   logic        floppy_irq_out, parallel_irq_out, parallel_irq_oe_n;
   wire logic   par_line;                            // Resolved pin
   logic [7:0]  low_len, pulses;                     // Pulse monitor
   logic [1:0]  k;                                   // Port code
   int          failures, num_checks;
   wire logic [7:0] outs;                            // All outputs

   // Same layout as the level register: oe_n,par,flp,s2,s1,b,a,irq
   assign outs = {parallel_irq_oe_n, parallel_irq_out, floppy_irq_out,
                  second_serial_irq_out, first_serial_irq_out,
                  host_serial_irq_b, host_serial_irq_a, irq};

   pir_top #(.JUMPER_W(4)) DUT (.aclk, .aresetn, .awvalid, .awready,
      .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
      .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
      .rresp, .hw_reset, .jumper_sel, .first_serial_cause,
      .second_serial_cause, .floppy_cause, .parallel_cause,
      .host_serial_irq_a, .host_serial_irq_b, .first_serial_irq_out,
      .second_serial_irq_out, .floppy_irq_out, .parallel_irq_out,
      .parallel_irq_oe_n, .irq);

   pir_host_model host (.aclk, .clr, .par_o(parallel_irq_out),
      .par_oe_n(parallel_irq_oe_n), .par_line, .low_len, .pulses);

   ////////////////////////////////////////////////////////////////
   // Clock: 50 MHz
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // Compare and count; four-state so an unknown never matches
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Write: address and data offered together, each dropped when taken;
   // bready stays high, so no wait is needed between writes
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      check({30'h0, bresp}, {30'h0, er});
   endtask

   // Read: address held until taken, data taken at the rvalid edge
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      check(rdata, exp);
      check({30'h0, rresp}, {30'h0, er});
   endtask

   task automatic give_verdict();
      if (failures == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Watchdog: tests need a few hundred cycles, allow 20000
   initial begin
      #400000;
      failures++;
      give_verdict();
   end

   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {awvalid, wvalid, arvalid, hw_reset, floppy_cause} = 5'h00;
      {awaddr, araddr, wdata, jumper_sel} = 52'h0;
      {first_serial_cause, second_serial_cause, parallel_cause} = 9'h0;
      {bready, rready, clr} = 3'h7;
      wstrb   = 4'hf;
      aresetn = 1'b0;
      tick(2);
      aresetn <= 1'b1;
      tick(1);
      check(32'(outs), 32'h00);
      rd(`PIR_CFG_OFF, 32'h08, `PIR_OKAY);
      rd(8'h24, 32'h0, `PIR_SLVERR);
      wr(8'h24, 32'hff, `PIR_SLVERR);
      // Route each port code to its host line
      wr(`PIR_EN1_OFF, 32'h0f, `PIR_OKAY);
      wr(`PIR_EN2_OFF, 32'h0f, `PIR_OKAY);
      for (int c = 0; c < 4; c++) begin
         k = 2'(c);
         wr(`PIR_CFG_OFF, 32'({k ^ 2'h1, k, 1'b0}), `PIR_OKAY);
         first_serial_cause <= 4'h1;
         tick(3);
         check(32'(outs), k[0] ? 32'h04 : 32'h02);
         first_serial_cause  <= 4'h0;
         second_serial_cause <= 4'h8;
         tick(3);
         check(32'(outs), k[0] ? 32'h02 : 32'h04);
         second_serial_cause <= 4'h0;
         tick(3);
         check(32'(outs), 32'h00);
      end
      // Enable gating, then disabling by enable and by reset
      wr(`PIR_CFG_OFF, 32'h08, `PIR_OKAY);
      wr(`PIR_EN1_OFF, 32'h01, `PIR_OKAY);
      first_serial_cause <= 4'he;
      tick(3);
      check(32'(outs), 32'h00);
      first_serial_cause <= 4'h1;
      tick(3);
      check(32'(outs), 32'h02);
      wr(`PIR_EN1_OFF, 32'h00, `PIR_OKAY);
      tick(3);
      check(32'(outs), 32'h00);
      wr(`PIR_EN1_OFF, 32'h0f, `PIR_OKAY);
      hw_reset <= 1'b1;
      tick(25);
      check(32'(outs), 32'h00);
      hw_reset <= 1'b0;
      tick(3);
      check(32'(outs), 32'h00);
      rd(`PIR_EN1_OFF, 32'h00, `PIR_OKAY);
      rd(`PIR_CFG_OFF, 32'h08, `PIR_OKAY);
      first_serial_cause <= 4'h0;
      // Adapter build: own outputs, jumpers latched at reset release
      wr(`PIR_CFG_OFF, 32'h09, `PIR_OKAY);
      wr(`PIR_EN1_OFF, 32'h0f, `PIR_OKAY);
      wr(`PIR_EN2_OFF, 32'h0f, `PIR_OKAY);
      first_serial_cause <= 4'h2;
      tick(3);
      check(32'(outs), 32'h08);
      first_serial_cause  <= 4'h0;
      second_serial_cause <= 4'h4;
      tick(3);
      check(32'(outs), 32'h10);
      second_serial_cause <= 4'h0;
      wr(`PIR_STAT_OFF, 32'h1f, `PIR_OKAY);
      jumper_sel <= 4'ha;
      hw_reset   <= 1'b1;
      tick(25);
      hw_reset <= 1'b0;
      tick(3);
      jumper_sel <= 4'h5;
      rd(`PIR_JMP_OFF, 32'h0a, `PIR_OKAY);
      rd(`PIR_STAT_OFF, 32'h10, `PIR_OKAY);
      rd(`PIR_CFG_OFF, 32'h09, `PIR_OKAY);
      // Floppy gating, sticky status, mask and clear
      wr(`PIR_CFG_OFF, 32'h08, `PIR_OKAY);
      floppy_cause <= 1'b1;
      tick(3);
      check(32'(outs), 32'h00);
      wr(`PIR_FLP_OFF, 32'h08, `PIR_OKAY);
      tick(3);
      check(32'(outs), 32'h20);
      floppy_cause <= 1'b0;
      wr(`PIR_STAT_OFF, 32'h1f, `PIR_OKAY);
      wr(`PIR_MASK_OFF, 32'h04, `PIR_OKAY);
      floppy_cause <= 1'b1;
      tick(3);
      check(32'(outs), 32'h21);
      // Level register mirrors the live pins
      rd(`PIR_LVL_OFF, 32'h21, `PIR_OKAY);
      floppy_cause <= 1'b0;
      tick(3);
      check(32'(outs), 32'h01);
      wr(`PIR_STAT_OFF, 32'h04, `PIR_OKAY);
      tick(3);
      check(32'(outs), 32'h00);
      wr(`PIR_MASK_OFF, 32'h00, `PIR_OKAY);
      // Parallel: plain level, then shared low pulses
      parallel_cause <= 1'b1;
      tick(3);
      check(32'(outs), 32'h00);
      wr(`PIR_PCTL_OFF, 32'h10, `PIR_OKAY);
      tick(3);
      check(32'(outs), 32'h40);
      parallel_cause <= 1'b0;
      tick(3);
      check(32'(outs), 32'h00);
      wr(`PIR_CFG_OFF, 32'h28, `PIR_OKAY);
      tick(3);
      clr <= 1'b0;
      for (int p = 1; p < 3; p++) begin
         parallel_cause <= 1'b1;
         tick(20);
         check(32'(low_len), `PIR_PULSE_CYC);
         check(32'(pulses), 32'(p));
         check(32'(outs), 32'h80);
         parallel_cause <= 1'b0;
         tick(3);
      end
      give_verdict();
   end
endmodule

`default_nettype wire
